/* hw/csm_clock_mode_ctrl.sv */
// clock source selection, oscillator mode register and wake-up sequencing
//
// Overview of operation
// RULE1: internal 16MHz RC runs in both internal fast clock options
// RULE2: internal-fast-only option releases both oscillator pins as GPIO
// RULE3: RTC option clocks system from internal RC, RTC from 32768Hz crystal
// RULE4: external 4/12MHz, 32KHz crystal or RC on input pin, per option
// RULE5: normal mode instruction rate is fast clock divided by 1 to 16
// RULE6: slow mode instruction rate is slow RC divided by four
// RULE7: slow RC drives watchdog clock and system clock when slow selected
// RULE8: slow RC stops only in power down or 32K green without watchdog
// RULE9: 8-bit mode register at 0CAH, bits 4..1 read/write, others zero
// RULE10: fast stop bit halts fast oscillator, slow RC keeps running
// RULE11: slow select bit picks slow RC as system clock, else fast clock
// RULE12: power mode field: 00 normal, 01 power down, 10 green, 11 reserved
// RULE13: fast stop disables RC, RTC crystal or external oscillator per option
// RULE14: after any reset wait 2048 fast cycles of warm-up
// RULE15: power down wake-up warms 2048 cycles for crystals, 32 for RC
// RULE16: power down and green requests clear on wake-up
// RULE17: entering slow mode leaves the fast oscillator running
// RULE18: after reset wait 256 slow RC cycles before the warm-up count
`timescale 1ns/10ps
`default_nettype none
module csm_clock_mode_ctrl
(
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic [2:0] i_fast_clock_option,
  input  wire logic [3:0] i_fcpu_divide,
  input  wire logic       i_watchdog_enable,
  input  wire logic       i_internal_fast_rc,
  input  wire logic       i_internal_slow_rc,
  input  wire logic       i_osc_in_pin,
  input  wire logic       i_wakeup,
  output logic            o_internal_fast_rc_en,
  output logic            o_internal_slow_rc_en,
  output logic            o_ext_osc_en,
  output logic            o_rtc_crystal_en,
  output logic            o_osc_in_pin_gpio,
  output logic            o_osc_out_pin_gpio,
  output logic            o_cpu_run,
  output logic            o_cpu_tick,
  output logic            o_watchdog_tick,
  output logic            o_rtc_tick,
  output logic            o_slow_mode
);
  import csm_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic [3:0] last_reg;
  logic [3:0] pins;
  logic [3:0] rise;

  assign pins = {i_wakeup, i_osc_in_pin, i_internal_slow_rc, i_internal_fast_rc};
  assign rise = sync_reg & ~last_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      meta_reg <= 4'h0;
      sync_reg <= 4'h0;
      last_reg <= 4'h0;
    end
    else
    begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  logic fast_rc_edge;
  logic slow_edge;
  logic pin_edge;
  logic wake_edge;
  logic opt_internal;
  logic opt_rtc;
  logic opt_crystal;
  logic fast_edge;

  assign fast_rc_edge = rise[0];
  assign slow_edge    = rise[1];
  assign pin_edge     = rise[2];
  assign wake_edge    = rise[3];

  // option decode
  assign opt_rtc      = (i_fast_clock_option == CSM_OPT_INT_FAST_RTC);
  assign opt_internal = (i_fast_clock_option == CSM_OPT_INT_FAST_ONLY) || opt_rtc; // RULE1
  assign opt_crystal  = (i_fast_clock_option == CSM_OPT_XTAL_32K)
                     || (i_fast_clock_option == CSM_OPT_XTAL_12M)
                     || (i_fast_clock_option == CSM_OPT_XTAL_4M);
  // fast clock from internal RC or from the input oscillator pin only
  assign fast_edge    = opt_internal ? fast_rc_edge : pin_edge; // RULE3 RULE4

  // ----------------------------------------------------------------
  // mode register and sequencer
  // ----------------------------------------------------------------
  logic          fast_stop_reg;
  logic          fast_stop_next;
  logic          slow_sel_reg;
  logic          slow_sel_next;
  logic [1:0]    power_mode_reg;
  logic [1:0]    power_mode_next;
  csm_state_type state_reg;
  csm_state_type state_next;
  logic          cfg_start;
  logic          warm_start;
  logic [11:0]   warm_limit;
  logic          wr_hit;

  csm_count_if cfg_if ();
  csm_count_if warm_if ();

  assign wr_hit = i_wr && (i_addr == CSM_OSC_MODE_ADDR);

  always_comb
  begin
    state_next      = state_reg;
    fast_stop_next  = fast_stop_reg;
    slow_sel_next   = slow_sel_reg;
    power_mode_next = power_mode_reg;
    cfg_start       = 1'b0;
    warm_start      = 1'b0;
    warm_limit      = CSM_WARMUP_XTAL;
    case (state_reg)
      CSM_ST_CONFIG:
      begin
        if (cfg_if.done)
        begin
          state_next = CSM_ST_WARMUP; // RULE18
          warm_start = 1'b1;
        end
      end
      CSM_ST_WARMUP:
      begin
        if (warm_if.done)
        begin
          state_next = CSM_ST_RUN; // RULE14
        end
      end
      CSM_ST_RUN:
      begin
        if (power_mode_reg == CSM_PM_POWER_DOWN)
        begin
          state_next = CSM_ST_POWER_DOWN; // RULE12
        end
        else if (power_mode_reg == CSM_PM_GREEN)
        begin
          state_next = CSM_ST_GREEN; // RULE12
        end
      end
      CSM_ST_POWER_DOWN:
      begin
        if (wake_edge)
        begin
          state_next      = CSM_ST_WARMUP;
          warm_start      = 1'b1;
          power_mode_next = CSM_PM_NORMAL; // RULE16
          slow_sel_next   = 1'b0;
        end
      end
      CSM_ST_GREEN:
      begin
        if (wake_edge)
        begin
          state_next      = CSM_ST_RUN;
          power_mode_next = CSM_PM_NORMAL; // RULE16
        end
      end
      default:
      begin
        state_next = CSM_ST_CONFIG;
        cfg_start  = 1'b1;
      end
    endcase
    // wake-up warm-up length depends on oscillator kind
    if (state_reg == CSM_ST_POWER_DOWN)
    begin
      warm_limit = opt_crystal ? CSM_WARMUP_XTAL : CSM_WARMUP_RC; // RULE15
    end
    // software write wins over the wake-up clear
    if (wr_hit)
    begin
      fast_stop_next  = i_wdata[CSM_FAST_STOP_BIT]; // RULE9
      slow_sel_next   = i_wdata[CSM_SLOW_SEL_BIT];
      power_mode_next = {i_wdata[CSM_GREEN_REQ_BIT], i_wdata[CSM_PDOWN_REQ_BIT]};
    end
  end

  logic [11:0] warm_limit_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state_reg      <= CSM_ST_CONFIG;
      fast_stop_reg  <= CSM_OSC_MODE_RESET[CSM_FAST_STOP_BIT]; // RULE9
      slow_sel_reg   <= CSM_OSC_MODE_RESET[CSM_SLOW_SEL_BIT];
      power_mode_reg <= CSM_OSC_MODE_RESET[CSM_GREEN_REQ_BIT:CSM_PDOWN_REQ_BIT];
      warm_limit_reg <= CSM_WARMUP_XTAL; // RULE14
    end
    else
    begin
      state_reg      <= state_next;
      fast_stop_reg  <= fast_stop_next;
      slow_sel_reg   <= slow_sel_next;
      power_mode_reg <= power_mode_next;
      if (warm_start)
      begin
        warm_limit_reg <= warm_limit;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration and warm-up counters
  // ----------------------------------------------------------------
  assign cfg_if.start  = cfg_start;
  assign cfg_if.tick   = slow_edge && (state_reg == CSM_ST_CONFIG);
  assign cfg_if.limit  = CSM_CFG_SLOW_CYCLES; // RULE18
  assign warm_if.start = warm_start;
  assign warm_if.tick  = fast_edge && (state_reg == CSM_ST_WARMUP);
  assign warm_if.limit = warm_start ? warm_limit : warm_limit_reg;

  csm_cycle_counter u_cfg_cnt
  (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .bus    (cfg_if)
  );

  csm_cycle_counter u_warm_cnt
  (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .bus    (warm_if)
  );

  // ----------------------------------------------------------------
  // oscillator enables and pin release
  // ----------------------------------------------------------------
  logic fast_run;
  logic slow_run;

  // slow select alone never stops the fast oscillator
  assign fast_run = (state_reg == CSM_ST_CONFIG) || (state_reg == CSM_ST_WARMUP)
                 || ((state_reg != CSM_ST_POWER_DOWN) && !fast_stop_reg); // RULE10 RULE17
  assign slow_run = (state_next != CSM_ST_POWER_DOWN)
                 && !((state_next == CSM_ST_GREEN)
                      && (i_fast_clock_option == CSM_OPT_XTAL_32K)
                      && !i_watchdog_enable); // RULE8

  // ----------------------------------------------------------------
  // instruction rate divider
  // ----------------------------------------------------------------
  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic [3:0] div_last;
  logic       src_edge;
  logic       cpu_tick_next;

  assign div_last = slow_sel_reg ? CSM_SLOW_DIV_LAST : i_fcpu_divide; // RULE5 RULE6
  assign src_edge = slow_sel_reg ? slow_edge : fast_edge; // RULE7 RULE11

  always_comb
  begin
    div_next      = div_reg;
    cpu_tick_next = 1'b0;
    if (state_reg != CSM_ST_RUN)
    begin
      div_next = 4'h0;
    end
    else if (src_edge)
    begin
      if (div_reg >= div_last)
      begin
        div_next      = 4'h0;
        cpu_tick_next = 1'b1;
      end
      else
      begin
        div_next = div_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs and read port
  // ----------------------------------------------------------------
  logic [7:0] rdata_next;

  always_comb
  begin
    rdata_next = 8'h00;
    if (i_rd && (i_addr == CSM_OSC_MODE_ADDR))
    begin
      rdata_next = {3'h0, power_mode_reg, slow_sel_reg, fast_stop_reg, 1'b0}
                 & CSM_OSC_MODE_MASK; // RULE9
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      div_reg               <= 4'h0;
      o_cpu_tick            <= 1'b0;
      o_rdata               <= 8'h00;
      o_internal_fast_rc_en <= 1'b0;
      o_internal_slow_rc_en <= 1'b1;
      o_ext_osc_en          <= 1'b0;
      o_rtc_crystal_en      <= 1'b0;
      o_osc_in_pin_gpio     <= 1'b0;
      o_osc_out_pin_gpio    <= 1'b0;
      o_cpu_run             <= 1'b0;
      o_watchdog_tick       <= 1'b0;
      o_rtc_tick            <= 1'b0;
      o_slow_mode           <= 1'b0;
    end
    else
    begin
      div_reg               <= div_next;
      o_cpu_tick            <= cpu_tick_next;
      o_rdata               <= rdata_next;
      o_internal_fast_rc_en <= opt_internal && fast_run; // RULE1 RULE13
      o_internal_slow_rc_en <= slow_run; // RULE8
      o_ext_osc_en          <= !opt_internal && fast_run; // RULE4 RULE13
      o_rtc_crystal_en      <= opt_rtc && fast_run; // RULE3 RULE13
      o_osc_in_pin_gpio     <= (i_fast_clock_option == CSM_OPT_INT_FAST_ONLY); // RULE2
      o_osc_out_pin_gpio    <= (i_fast_clock_option == CSM_OPT_INT_FAST_ONLY)
                            || (i_fast_clock_option == CSM_OPT_EXT_RC); // RULE2 RULE4
      o_cpu_run             <= (state_next == CSM_ST_RUN);
      o_watchdog_tick       <= slow_edge && slow_run; // RULE7
      o_rtc_tick            <= opt_rtc && pin_edge;
      o_slow_mode           <= slow_sel_reg; // RULE11
    end
  end

endmodule : csm_clock_mode_ctrl
`default_nettype wire

/* hw/csm_pkg.sv */
// constants and types shared by the clock source and mode control block
package csm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CSM_OSC_MODE_ADDR   = 8'h0ca;
  localparam logic [7:0] CSM_OSC_MODE_RESET  = 8'h00;
  localparam int         CSM_FAST_STOP_BIT   = 1;
  localparam int         CSM_SLOW_SEL_BIT    = 2;
  localparam int         CSM_PDOWN_REQ_BIT   = 3;
  localparam int         CSM_GREEN_REQ_BIT   = 4;
  localparam logic [7:0] CSM_OSC_MODE_MASK   = 8'h1e;

  // ----------------------------------------------------------------
  // power mode field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CSM_PM_NORMAL       = 2'h0;
  localparam logic [1:0] CSM_PM_POWER_DOWN   = 2'h1;
  localparam logic [1:0] CSM_PM_GREEN        = 2'h2;

  // ----------------------------------------------------------------
  // fast clock build options
  // ----------------------------------------------------------------
  localparam logic [2:0] CSM_OPT_INT_FAST_ONLY = 3'h0;
  localparam logic [2:0] CSM_OPT_INT_FAST_RTC  = 3'h1;
  localparam logic [2:0] CSM_OPT_EXT_RC        = 3'h2;
  localparam logic [2:0] CSM_OPT_XTAL_32K      = 3'h3;
  localparam logic [2:0] CSM_OPT_XTAL_12M      = 3'h4;
  localparam logic [2:0] CSM_OPT_XTAL_4M       = 3'h5;

  // ----------------------------------------------------------------
  // timing counts, in oscillator cycles
  // ----------------------------------------------------------------
  localparam int         CSM_CNT_W           = 12;
  localparam logic [11:0] CSM_CFG_SLOW_CYCLES = 12'h0100;
  localparam logic [11:0] CSM_WARMUP_XTAL     = 12'h0800;
  localparam logic [11:0] CSM_WARMUP_RC       = 12'h0020;
  localparam logic [3:0]  CSM_SLOW_DIV_LAST   = 4'h3;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSM_ST_CONFIG,
    CSM_ST_WARMUP,
    CSM_ST_RUN,
    CSM_ST_POWER_DOWN,
    CSM_ST_GREEN
  } csm_state_type;

endpackage : csm_pkg

/* hw/csm_count_if.sv */
// handshake between the sequencer and a cycle counter
`timescale 1ns/10ps
`default_nettype none
interface csm_count_if;
  import csm_pkg::*;
  logic                 start;
  logic                 tick;
  logic [CSM_CNT_W-1:0] limit;
  logic                 done;
  modport ctrl (output start, output tick, output limit, input done);
  modport cnt  (input start, input tick, input limit, output done);
endinterface : csm_count_if
`default_nettype wire

/* hw/csm_cycle_counter.sv */
// counts oscillator ticks up to a limit and then holds done
`timescale 1ns/10ps
`default_nettype none
module csm_cycle_counter
(
  input  wire logic   i_clk,
  input  wire logic   i_srst,
  csm_count_if.cnt    bus
);
  import csm_pkg::*;

  logic [CSM_CNT_W-1:0] count_reg;
  logic [CSM_CNT_W-1:0] count_next;
  logic                 done_reg;
  logic                 done_next;

  always_comb
  begin
    count_next = count_reg;
    done_next  = done_reg;
    if (bus.start)
    begin
      count_next = '0;
      done_next  = 1'b0;
    end
    else if (bus.tick && !done_reg)
    begin
      count_next = count_reg + 1'b1;
      if (count_next == bus.limit)
      begin
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      count_reg <= '0;
      done_reg  <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      done_reg  <= done_next;
    end
  end

  assign bus.done = done_reg;

endmodule : csm_cycle_counter
`default_nettype wire

/* hw/README_unused.sv */
// intentionally empty compilation unit
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* test/csm_osc_model.sv */
// oscillator sources seen by the clock mode block: fast rc, slow rc, pin oscillator
`timescale 1ns/10ps
`default_nettype none
module csm_osc_model
(
  input  wire logic i_clk,
  input  wire logic i_fast_en,
  input  wire logic i_slow_en,
  input  wire logic i_pin_en,
  output logic      o_fast,
  output logic      o_slow,
  output logic      o_pin
);
  logic [1:0] slow_cnt;
  // ----------------------------------------------------------------
  // each source runs only while enabled, a stopped one sits low
  // ----------------------------------------------------------------
  initial
  begin
    o_fast   = 1'b0;
    o_slow   = 1'b0;
    o_pin    = 1'b0;
    slow_cnt = 2'h0;
  end
  always @(negedge i_clk)
  begin
    o_fast   <= i_fast_en ? ~o_fast : 1'b0;
    o_pin    <= i_pin_en ? ~o_pin : 1'b0;
    slow_cnt <= i_slow_en ? slow_cnt + 2'h1 : 2'h0;
    o_slow   <= i_slow_en ? slow_cnt[1] : 1'b0;
  end
endmodule : csm_osc_model
`default_nettype wire

/* test/csm_clock_mode_ctrl_sva.sv */
// assertions on the ports of the clock mode block
`timescale 1ns/10ps
`default_nettype none
module csm_clock_mode_ctrl_sva
  import csm_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] o_rdata,
  input  wire logic [2:0] i_fast_clock_option,
  input  wire logic       i_watchdog_enable,
  input  wire logic       o_internal_slow_rc_en,
  input  wire logic       o_osc_in_pin_gpio,
  input  wire logic       o_cpu_run,
  input  wire logic       o_cpu_tick,
  input  wire logic       o_slow_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // ----------------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------------
  sequence s_mode_wr(logic [1:0] m);
    i_wr && i_addr == CSM_OSC_MODE_ADDR && i_wdata[4:3] == m && o_cpu_run;
  endsequence
  sequence s_halted;
    !o_cpu_run && !o_internal_slow_rc_en;
  endsequence
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  property p_rd_resv;
    $past(i_rd) |-> (o_rdata & ~CSM_OSC_MODE_MASK) == 8'h00;
  endproperty
  property p_rd_unmapped;
    $past(i_rd) && $past(i_addr) != CSM_OSC_MODE_ADDR |-> o_rdata == 8'h00;
  endproperty
  property p_pd_entry;
    s_mode_wr(CSM_PM_POWER_DOWN) |-> ##[1:3] s_halted;
  endproperty
  property p_green_entry;
    s_mode_wr(CSM_PM_GREEN) ##0 i_watchdog_enable |->
      o_internal_slow_rc_en throughout (##[1:3] !o_cpu_run);
  endproperty
  property p_gpio;
    !$past(i_srst) |-> o_osc_in_pin_gpio == (i_fast_clock_option == CSM_OPT_INT_FAST_ONLY);
  endproperty
  property p_run_slow;
    o_cpu_run |-> o_internal_slow_rc_en;
  endproperty
  property p_tick_run;
    !$past(o_cpu_run) && !o_cpu_run |-> !o_cpu_tick;
  endproperty
  property p_slow_tick;
    o_slow_mode && o_cpu_tick |=> (!o_cpu_tick || !o_slow_mode) [*6];
  endproperty
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  a_rd_resv: assert property (p_rd_resv) else $error("reserved bits read non zero");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  a_pd_entry: assert property (p_pd_entry) else $error("power down not entered");
  a_green_entry: assert property (p_green_entry) else $error("green entry wrong");
  a_gpio: assert property (p_gpio) else $error("input pin gpio release wrong");
  a_run_slow: assert property (p_run_slow) else $error("slow rc off while running");
  a_tick_run: assert property (p_tick_run) else $error("tick while halted");
  a_slow_tick: assert property (p_slow_tick) else $error("slow tick too fast");
endmodule : csm_clock_mode_ctrl_sva
bind csm_clock_mode_ctrl csm_clock_mode_ctrl_sva csm_clock_mode_ctrl_sva_inst (.i_clk, .i_srst,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_fast_clock_option, .i_watchdog_enable,
  .o_internal_slow_rc_en, .o_osc_in_pin_gpio, .o_cpu_run, .o_cpu_tick, .o_slow_mode);
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the clock mode block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import csm_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_srst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [2:0] opt = 3'h0;
  logic [3:0] div = 4'h3;
  logic       i_wakeup = 1'b0;
  logic       wd_en = 1'b1;
  logic       rtc_tick;
  logic       fast, slow, pin, fast_en, slow_en, ext_en, rtc_en, in_gpio, out_gpio;
  logic       run, tick, wd_tick, slow_mode;
  logic [7:0] o_rdata;
  int         bad_count = 0;
  int         n_tests = 0;
  int         n, t, w, r;
  always #5 i_clk = ~i_clk;
  csm_osc_model csm_osc_model_inst (.i_clk(i_clk), .i_fast_en(fast_en), .i_slow_en(slow_en),
    .i_pin_en(ext_en | rtc_en), .o_fast(fast), .o_slow(slow), .o_pin(pin));
  csm_clock_mode_ctrl csm_clock_mode_ctrl_inst (.i_clk(i_clk), .i_srst(i_srst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_fast_clock_option(opt), .i_fcpu_divide(div), .i_watchdog_enable(wd_en),
    .i_internal_fast_rc(fast), .i_internal_slow_rc(slow), .i_osc_in_pin(pin),
    .i_wakeup(i_wakeup), .o_internal_fast_rc_en(fast_en), .o_internal_slow_rc_en(slow_en),
    .o_ext_osc_en(ext_en), .o_rtc_crystal_en(rtc_en), .o_osc_in_pin_gpio(in_gpio),
    .o_osc_out_pin_gpio(out_gpio), .o_cpu_run(run), .o_cpu_tick(tick),
    .o_watchdog_tick(wd_tick), .o_rtc_tick(rtc_tick), .o_slow_mode(slow_mode));
  // ----------------------------------------------------------------
  // compare, bus and sequencing tasks
  // ----------------------------------------------------------------
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task chk_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : chk_rng
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask : rd
  task wait_run(output int c);
    c = 0;
    while (run !== 1'b1 && c < 9000)
    begin
      @(posedge i_clk);
      c++;
    end
  endtask : wait_run
  task reset_to(input logic [2:0] o, input logic [3:0] d, output int c);
    @(posedge i_clk);
    i_srst <= 1'b1;
    opt    <= o;
    div    <= d;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    wait_run(c);
  endtask : reset_to
  task count_ticks;
    t = 0;
    w = 0;
    r = 0;
    repeat (400)
    begin
      @(posedge i_clk);
      #1;
      if (tick === 1'b1) t++;
      if (wd_tick === 1'b1) w++;
      if (rtc_tick === 1'b1) r++;
    end
  endtask : count_ticks
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    #900000;
    bad_count++;
    end_of_test();
  end
  initial
  begin
    reset_to(3'h0, 4'h3, n);
    chk_rng(n, 5120, 5170);
    rd(8'hca, 8'h00);
    wr(8'hcb, 8'h1e);
    rd(8'hca, 8'h00);
    rd(8'hcb, 8'h00);
    wr(8'hca, 8'hff);
    rd(8'hca, 8'h1e);
    chk(run, 1'b1);
    wr(8'hca, 8'h00);
    $display("register test done");
    count_ticks();
    chk_rng(t, 48, 52);
    chk_rng(w, 98, 102);
    wr(8'hca, 8'h04);
    count_ticks();
    chk_rng(t, 24, 26);
    chk(slow_mode, 1'b1);
    chk(fast_en, 1'b1);
    wr(8'hca, 8'h06);
    repeat (4) @(posedge i_clk);
    chk(fast_en, 1'b0);
    chk(slow_en, 1'b1);
    wr(8'hca, 8'h00);
    repeat (4) @(posedge i_clk);
    $display("rate test done");
    wr(8'hca, 8'h10);
    repeat (4) @(posedge i_clk);
    chk(run, 1'b0);
    chk(slow_en, 1'b1);
    i_wakeup <= 1'b1;
    repeat (10) @(posedge i_clk);
    i_wakeup <= 1'b0;
    chk(run, 1'b1);
    rd(8'hca, 8'h00);
    $display("green test done");
    for (int o = 0; o < 6; o++)
    begin
      reset_to(o[2:0], 4'h0, n);
      chk_rng(n, 5120, 5170);
      chk(in_gpio, (o == 0));
      chk(out_gpio, (o == 0 || o == 2));
      chk(fast_en, (o < 2));
      chk(ext_en, (o >= 2));
      chk(rtc_en, (o == 1));
      count_ticks();
      chk_rng(t, 198, 202);
      chk_rng(r, (o == 1) ? 198 : 0, (o == 1) ? 202 : 0);
      wr(8'hca, 8'h08);
      repeat (4) @(posedge i_clk);
      chk(slow_en, 1'b0);
      chk(run, 1'b0);
      i_wakeup <= 1'b1;
      wait_run(n);
      i_wakeup <= 1'b0;
      if (o >= 3) chk_rng(n, 4096, 4130);
      else chk_rng(n, 64, 98);
      rd(8'hca, 8'h00);
      $display("option %0d test done", o);
    end
    wd_en <= 1'b0;
    reset_to(3'h3, 4'h0, n);
    chk_rng(n, 5120, 5170);
    wr(8'hca, 8'h10);
    repeat (4) @(posedge i_clk);
    chk(run, 1'b0);
    chk(slow_en, 1'b0);
    i_wakeup <= 1'b1;
    repeat (10) @(posedge i_clk);
    i_wakeup <= 1'b0;
    chk(run, 1'b1);
    chk(slow_en, 1'b1);
    $display("watchdog off green test done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
